/* File: hpid_dma_model.sv */
// external dma controller model facing the request pin of the host port
`timescale 1ns/1ns
module hpid_dma_model (
  input wire logic ref_clk,
  input wire logic host_request_out_n,
  output logic host_acknowledge_in_n,
  output logic [7:0] host_data_in,
  output logic active,
  output int errs
);
  initial begin
    host_acknowledge_in_n = 1'b1;
    host_data_in = 8'h00;
    active = 1'b0;
    errs = 0;
  end
  // bytes come from the model's own memory list, the port picks the register
  task automatic run(input logic [7:0] b[$], input int dly);
    int n;
    @(negedge ref_clk);
    active = 1'b1;
    foreach (b[i]) begin
      n = 0;
      while (host_request_out_n !== 1'b0 && n < 300) begin
        @(negedge ref_clk);
        n++;
      end
      if (n == 300) errs++;
      repeat (dly) @(negedge ref_clk);
      // one byte per acknowledge, held until the request drops
      host_data_in = b[i];
      host_acknowledge_in_n = 1'b0;
      n = 0;
      while (host_request_out_n !== 1'b1 && n < 20) begin
        @(negedge ref_clk);
        n++;
      end
      if (n == 20) errs++;
      @(negedge ref_clk);
      host_acknowledge_in_n = 1'b1;
      host_data_in = ~b[i];
    end
    active = 1'b0;
  endtask : run
endmodule : hpid_dma_model

/* File: hpid_fifo.sv */
// shift-register buffer, head entry always at index zero
`timescale 1ns/1ns
module hpid_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 2
) (
  input wire logic ref_clk,
  input wire logic rstn,
  hpid_stream_if.snk in_s,
  hpid_stream_if.src out_s
);
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] mem_q [DEPTH];
  logic [CW-1:0] count_q;
  logic push;
  logic pop;
  logic [CW-1:0] wr_idx;
  assign in_s.ready = (count_q != CW'(DEPTH));
  assign out_s.valid = (count_q != '0);
  assign out_s.data = mem_q[0];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;
  assign wr_idx = count_q - CW'(pop);
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      count_q <= '0;
    end else begin
      count_q <= count_q + CW'(push) - CW'(pop);
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (push && CW'(i) == wr_idx) begin
          mem_q[i] <= in_s.data;
        end else if (pop && i < DEPTH - 1) begin
          mem_q[i] <= mem_q[i + 1];
        end
      end
    end
  end
endmodule : hpid_fifo

/* File: hpid_pkg.sv */
// constants, field positions and types for the host port inbound dma block
package hpid_pkg;
  // ********************
  // register offsets
  // ********************
  localparam logic [2:0] ICR_OFS = 3'h0;
  localparam logic [2:0] CMD_OFS = 3'h1;
  localparam logic [2:0] STAT_OFS = 3'h2;
  localparam logic [2:0] VEC_OFS = 3'h3;
  localparam logic [2:0] HIGH_OFS = 3'h6;
  localparam logic [2:0] LOW_OFS = 3'h7;
  // ********************
  // field positions
  // ********************
  localparam int ICR_RREQ = 0;
  localparam int ICR_TREQ = 1;
  localparam int ICR_HM0 = 5;
  localparam int ICR_HM1 = 6;
  localparam int ICR_INIT = 7;
  localparam int CMD_HC = 7;
  // ********************
  // reset values and sizes
  // ********************
  localparam logic [7:0] VEC_RST = 8'h0f;
  localparam logic [7:0] ICR_RST = 8'h00;
  localparam logic [1:0] CNT_LAST = 2'h3;
  localparam int BUF_DEPTH = 2;
  localparam int WORD_W = 16;
  typedef enum logic [1:0] {
    HPID_IRQ_MODE = 2'b00,
    HPID_ILLEGAL = 2'b01,
    HPID_DMA16 = 2'b10,
    HPID_DMA8 = 2'b11
  } hpid_mode_type;
  typedef enum logic [0:0] {
    HS_READY = 1'b0,
    HS_WAIT_RELEASE = 1'b1
  } hpid_hs_type;
endpackage : hpid_pkg

/* File: hpid_stream_if.sv */
// valid/ready word carrier between the port and its receive buffer
`timescale 1ns/1ns
interface hpid_stream_if #(parameter int W = 16);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface : hpid_stream_if

/* File: hpid_sync.sv */
// two flip-flop synchroniser for pins
`timescale 1ns/1ns
module hpid_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= RST;
      q <= RST;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : hpid_sync

/* File: hpid_top.sv */
// host port: status, vector, request pin and host-to-core dma
// Operation
// - status bit 5 always reads zero
// - status bit 6 is one when either mode bit is set
// - status bit 7 mirrors the request pin
// - request asserts on enabled receive-full or enabled transmit-empty
// - reset clears the request status and releases the pin
// - vector register is 8-bit, host read/write, not core-visible
// - vector driven on data lines when request and acknowledge meet, dma off
// - reset loads vector with 0f
// - host command clears on core acknowledge; others on register access
// - dma transfers select registers from the address counter
// - dma moves 8-bit or 16-bit words chosen by mode bits
// - host-to-core dma requests while transmit-empty is one and the handshake is ready with acknowledge released
// - acknowledge latches data into selected byte and drops request
// - before last byte: step counter, await acknowledge release
// - after last byte: reload counter, move pair to core when room
// - core exception follows receive-full; clears once core reads empty the buffer
// - requesting resumes by itself; exception ignores the handshake
// - dma forces top select bit one, counter gives low bits
// - transmit-empty clears on low byte write, sets on hand-off
// - in dma, acknowledge is transfer acknowledge, no host interrupts
`timescale 1ns/1ns
module hpid_top (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [2:0] host_addr,
  input wire logic host_rw,
  input wire logic host_enable_n,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  input wire logic host_acknowledge_in_n,
  output logic host_request_out_n,
  input wire logic core_receive_read,
  output logic [hpid_pkg::WORD_W-1:0] core_receive_reg,
  output logic core_receive_full,
  output logic host_receive_exception,
  input wire logic core_tx_write,
  input wire logic [hpid_pkg::WORD_W-1:0] core_tx_data,
  output logic core_transmit_empty,
  input wire logic [1:0] core_host_flags,
  input wire logic core_int_ack,
  output logic host_command_irq
);
  import hpid_pkg::*;
  // ********************
  // pin synchronisers
  // ********************
  logic [2:0] addr_s;
  logic rw_s;
  logic en_s;
  logic ack_s;
  logic [7:0] data_s;
  logic en_d_q;
  logic ack_d_q;
  hpid_sync #(.W(14), .RST(14'h0)) u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .d({host_addr, host_rw, ~host_enable_n, ~host_acknowledge_in_n, host_data_in}),
    .q({addr_s, rw_s, en_s, ack_s, data_s})
  );
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      en_d_q <= 1'b0;
      ack_d_q <= 1'b0;
    end else begin
      en_d_q <= en_s;
      ack_d_q <= ack_s;
    end
  end
  // ********************
  // decode
  // ********************
  logic [7:0] icr_q;
  logic [7:0] vec_q;
  logic hc_q;
  logic [7:0] tx_byte_high_q;
  logic [7:0] tx_byte_low_q;
  logic [7:0] rx_byte_high_q;
  logic [7:0] rx_byte_low_q;
  logic transmit_empty_flag_q;
  logic receive_full_flag_q;
  logic [1:0] cnt_q;
  logic req_q;
  logic exc_q;
  logic cte_q;
  logic [7:0] dout_q;
  logic oe_q;
  hpid_hs_type hs_q;
  hpid_mode_type mode;
  logic hm_any;
  logic irq_mode;
  logic dma_h2c;
  logic acc_start;
  logic wr_start;
  logic rd_start;
  logic ack_rise;
  logic dma_take;
  logic init_go;
  logic [2:0] dma_sel;
  logic push_ok;
  logic [7:0] status;
  logic [7:0] rd_mux;
  assign mode = hpid_mode_type'({icr_q[ICR_HM1], icr_q[ICR_HM0]});
  assign hm_any = icr_q[ICR_HM1] | icr_q[ICR_HM0];
  assign irq_mode = (mode == HPID_IRQ_MODE);
  assign dma_h2c = icr_q[ICR_HM1] & icr_q[ICR_TREQ];
  assign acc_start = en_s & ~en_d_q;
  assign wr_start = acc_start & ~rw_s;
  assign rd_start = acc_start & rw_s;
  assign ack_rise = ack_s & ~ack_d_q;
  assign dma_take = dma_h2c & ack_rise & (hs_q == HS_READY);
  assign init_go = wr_start & (addr_s == ICR_OFS) & data_s[ICR_INIT];
  assign dma_sel = {1'b1, cnt_q};
  // ********************
  // receive buffer toward the core
  // ********************
  hpid_stream_if #(.W(WORD_W)) to_buf ();
  hpid_stream_if #(.W(WORD_W)) from_buf ();
  assign to_buf.valid = ~transmit_empty_flag_q;
  assign to_buf.data = {tx_byte_high_q, tx_byte_low_q};
  assign push_ok = to_buf.valid & to_buf.ready;
  assign from_buf.ready = core_receive_read;
  hpid_fifo #(.W(WORD_W), .DEPTH(BUF_DEPTH)) u_buf (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .in_s(to_buf),
    .out_s(from_buf)
  );
  assign core_receive_reg = from_buf.data;
  assign core_receive_full = from_buf.valid;
  // ********************
  // control register and mode bits
  // ********************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      icr_q <= ICR_RST;
    end else if (wr_start && addr_s == ICR_OFS) begin
      icr_q <= {1'b0, data_s[6:0]};
    end
  end
  // ********************
  // vector register
  // ********************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      vec_q <= VEC_RST;
    end else if (wr_start && addr_s == VEC_OFS) begin
      vec_q <= data_s;
    end
  end
  // ********************
  // host command toward the core
  // ********************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hc_q <= 1'b0;
    end else if (wr_start && addr_s == CMD_OFS) begin
      hc_q <= data_s[CMD_HC];
    end else if (core_int_ack) begin
      hc_q <= 1'b0;
    end
  end
  assign host_command_irq = hc_q;
  // ********************
  // transmit byte pair
  // ********************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tx_byte_high_q <= 8'h00;
      tx_byte_low_q <= 8'h00;
    end else if (dma_take) begin
      if (dma_sel == HIGH_OFS) begin
        tx_byte_high_q <= data_s;
      end else if (dma_sel == LOW_OFS) begin
        tx_byte_low_q <= data_s;
      end
    end else if (wr_start && addr_s == HIGH_OFS) begin
      tx_byte_high_q <= data_s;
    end else if (wr_start && addr_s == LOW_OFS) begin
      tx_byte_low_q <= data_s;
    end
  end
  // ********************
  // transmit-empty flag, set wins
  // ********************
  logic low_write;
  assign low_write = (dma_take && dma_sel == LOW_OFS) || (wr_start && addr_s == LOW_OFS);
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      transmit_empty_flag_q <= 1'b1;
    end else if (push_ok || (init_go && data_s[ICR_TREQ])) begin
      transmit_empty_flag_q <= 1'b1;
    end else if (low_write) begin
      transmit_empty_flag_q <= 1'b0;
    end
  end
  // ********************
  // receive byte pair from the core
  // ********************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_byte_high_q <= 8'h00;
      rx_byte_low_q <= 8'h00;
    end else if (core_tx_write && !receive_full_flag_q) begin
      rx_byte_high_q <= core_tx_data[15:8];
      rx_byte_low_q <= core_tx_data[7:0];
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      receive_full_flag_q <= 1'b0;
    end else if (core_tx_write && !receive_full_flag_q) begin
      receive_full_flag_q <= 1'b1;
    end else if ((rd_start && addr_s == LOW_OFS) || (init_go && data_s[ICR_RREQ])) begin
      receive_full_flag_q <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cte_q <= 1'b1;
    end else begin
      cte_q <= ~receive_full_flag_q & ~(core_tx_write & ~receive_full_flag_q);
    end
  end
  assign core_transmit_empty = cte_q;
  // ********************
  // dma address counter and handshake
  // ********************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 2'h0;
    end else if (init_go) begin
      cnt_q <= {data_s[ICR_HM1], data_s[ICR_HM0]};
    end else if (dma_take) begin
      if (cnt_q != CNT_LAST) begin
        cnt_q <= cnt_q + 2'h1;
      end else begin
        cnt_q <= {icr_q[ICR_HM1], icr_q[ICR_HM0]};
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hs_q <= HS_READY;
    end else begin
      case (hs_q)
        HS_READY: begin
          if (dma_take) begin
            hs_q <= HS_WAIT_RELEASE;
          end
        end
        HS_WAIT_RELEASE: begin
          if (!ack_s) begin
            hs_q <= HS_READY;
          end
        end
        default: begin
          hs_q <= HS_READY;
        end
      endcase
    end
  end
  // ********************
  // request pin
  // ********************
  logic req_d;
  always_comb begin
    req_d = 1'b0;
    if (irq_mode) begin
      req_d = (receive_full_flag_q & icr_q[ICR_RREQ]) |
              (transmit_empty_flag_q & icr_q[ICR_TREQ]);
    end else if (dma_h2c) begin
      req_d = transmit_empty_flag_q & (hs_q == HS_READY) & ~ack_s;
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      req_q <= 1'b0;
    end else begin
      req_q <= req_d;
    end
  end
  assign host_request_out_n = ~req_q;
  // ********************
  // core exception
  // ********************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      exc_q <= 1'b0;
    end else begin
      exc_q <= from_buf.valid;
    end
  end
  assign host_receive_exception = exc_q;
  // ********************
  // host read data
  // ********************
  assign status = {req_q, hm_any, 1'b0, core_host_flags,
                   transmit_empty_flag_q & ~from_buf.valid,
                   transmit_empty_flag_q, receive_full_flag_q};
  always_comb begin
    case (addr_s)
      ICR_OFS: rd_mux = icr_q;
      CMD_OFS: rd_mux = {hc_q, 7'h00};
      STAT_OFS: rd_mux = status;
      VEC_OFS: rd_mux = vec_q;
      HIGH_OFS: rd_mux = rx_byte_high_q;
      LOW_OFS: rd_mux = rx_byte_low_q;
      default: rd_mux = 8'h00;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      dout_q <= 8'h00;
      oe_q <= 1'b0;
    end else if (req_q && ack_s && !hm_any) begin
      dout_q <= vec_q;
      oe_q <= 1'b1;
    end else begin
      dout_q <= rd_mux;
      oe_q <= en_s & rw_s;
    end
  end
  assign host_data_out = dout_q;
  assign host_data_oe = oe_q;
  // ********************
  // checks
  // ********************
  sequence s_ack_take;
    dma_take;
  endsequence
  sequence s_stat_read;
    en_s && rw_s && addr_s == STAT_OFS && !(req_q && ack_s && !hm_any);
  endsequence
  property p_stat_bit(int b, logic v);
    @(posedge ref_clk) disable iff (!rstn) s_stat_read |=> host_data_out[b] == v;
  endproperty
  stat_reserved_a: assert property (p_stat_bit(5, 1'b0)) else $error("bit 5 not zero");
  dma_status_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_stat_read |=> host_data_out[6] == $past(hm_any)) else $error("dma bit wrong");
  req_status_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_stat_read |=> host_data_out[7] == $past(~host_request_out_n)) else $error("req bit");
  irq_request_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    irq_mode && ((receive_full_flag_q && icr_q[ICR_RREQ]) || (transmit_empty_flag_q &&
    icr_q[ICR_TREQ])) |=> !host_request_out_n) else $error("no request");
  vector_drive_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    req_q && ack_s && !hm_any |=> host_data_oe && host_data_out == $past(vec_q))
    else $error("vector not driven");
  dma_request_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    dma_h2c && transmit_empty_flag_q && hs_q == HS_READY && !ack_s |=> !host_request_out_n)
    else $error("dma request missing");
  ack_drop_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_ack_take |=> host_request_out_n [*2]) else $error("request kept");
  counter_step_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_ack_take and cnt_q != CNT_LAST |=> cnt_q == $past(cnt_q) + 2'h1)
    else $error("counter step");
  counter_reload_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_ack_take and cnt_q == CNT_LAST |=> cnt_q == $past({icr_q[ICR_HM1], icr_q[ICR_HM0]}))
    else $error("counter reload");
  core_exception_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    from_buf.valid |=> host_receive_exception) else $error("exception late");
  cmd_clear_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    core_int_ack && !(wr_start && addr_s == CMD_OFS) |=> !host_command_irq)
    else $error("command kept");
endmodule : hpid_top

/* File: tb_top.sv */
// self-checking testbench of the host port inbound dma block
`timescale 1ns/1ns
module tb_top;
  import hpid_pkg::*;
  // ********************
  // signals
  // ********************
  logic ref_clk, rstn, host_rw, host_enable_n, host_data_oe, tb_ack_n, dma_ack_n;
  logic [2:0] host_addr;
  logic [7:0] tb_data, dma_data, host_data_out;
  logic host_request_out_n, dma_on, core_receive_read, core_receive_full;
  logic host_receive_exception, core_tx_write, core_transmit_empty;
  logic core_int_ack, host_command_irq;
  logic [15:0] core_receive_reg, core_tx_data;
  int checks = 0;
  int fail_count = 0;
  int dma_errs;
  hpid_top i_dut (.ref_clk(ref_clk), .rstn(rstn), .host_addr(host_addr),
    .host_rw(host_rw), .host_enable_n(host_enable_n),
    .host_data_in(dma_on ? dma_data : tb_data), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .host_acknowledge_in_n(tb_ack_n & dma_ack_n),
    .host_request_out_n(host_request_out_n), .core_receive_read(core_receive_read),
    .core_receive_reg(core_receive_reg), .core_receive_full(core_receive_full),
    .host_receive_exception(host_receive_exception), .core_tx_write(core_tx_write),
    .core_tx_data(core_tx_data), .core_transmit_empty(core_transmit_empty),
    .core_host_flags(2'b10), .core_int_ack(core_int_ack),
    .host_command_irq(host_command_irq));
  hpid_dma_model i_dma (.ref_clk(ref_clk), .host_request_out_n(host_request_out_n),
    .host_acknowledge_in_n(dma_ack_n), .host_data_in(dma_data), .active(dma_on),
    .errs(dma_errs));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ********************
  // tasks
  // ********************
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t byte %h expected %h", $time, g, e);
    end
  endtask : chk_byte
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t word %h expected %h", $time, g, e);
    end
  endtask : chk_word
  task automatic chk_bit(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t bit %b expected %b", $time, g, e);
    end
  endtask : chk_bit
  task automatic acc(input logic [2:0] a, input logic rw, input logic [7:0] d,
      output logic [7:0] q);
    @(negedge ref_clk);
    host_addr = a;
    host_rw = rw;
    tb_data = d;
    host_enable_n = 1'b0;
    repeat (5) @(negedge ref_clk);
    q = host_data_out;
    if (rw) chk_bit(host_data_oe, 1'b1);
    host_enable_n = 1'b1;
    tb_data = ~d;
    repeat (4) @(negedge ref_clk);
  endtask : acc
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(a, 1'b0, d, q);
  endtask : wr
  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] q;
    acc(a, 1'b1, 8'h00, q);
    chk_byte(q, e);
  endtask : rchk
  task automatic wait_req(input logic lvl);
    int n;
    n = 0;
    while (host_request_out_n !== lvl && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    chk_bit(host_request_out_n, lvl);
    if (host_request_out_n !== lvl) final_report();
  endtask : wait_req
  task automatic pop(input logic [15:0] e);
    chk_word(core_receive_reg, e);
    @(negedge ref_clk);
    core_receive_read = 1'b1;
    @(negedge ref_clk);
    core_receive_read = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask : pop
  task automatic do_reset;
    rstn = 1'b0;
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    rstn = 1'b1;
    repeat (2) @(negedge ref_clk);
  endtask : do_reset
  initial begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    final_report();
  end
  // ********************
  // tests
  // ********************
  initial begin
    host_addr = 3'h0;
    host_rw = 1'b1;
    host_enable_n = 1'b1;
    tb_data = 8'h00;
    tb_ack_n = 1'b1;
    core_receive_read = 1'b0;
    core_tx_write = 1'b0;
    core_tx_data = 16'h0000;
    core_int_ack = 1'b0;
    rstn = 1'b0;
    do_reset();
    chk_bit(host_request_out_n, 1'b1);
    rchk(VEC_OFS, VEC_RST);
    rchk(STAT_OFS, 8'h16);
    wr(VEC_OFS, 8'ha5);
    rchk(VEC_OFS, 8'ha5);
    wr(STAT_OFS, 8'hff);
    rchk(STAT_OFS, 8'h16);
    rchk(3'h4, 8'h00);
    $display("test registers done");
    wr(ICR_OFS, 8'h02);
    wait_req(1'b0);
    rchk(STAT_OFS, 8'h96);
    tb_ack_n = 1'b0;
    repeat (5) @(negedge ref_clk);
    chk_byte(host_data_out, 8'ha5);
    chk_bit(host_data_oe, 1'b1);
    tb_ack_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    wr(ICR_OFS, 8'h01);
    wait_req(1'b1);
    core_tx_data = 16'hbeef;
    core_tx_write = 1'b1;
    @(negedge ref_clk);
    core_tx_write = 1'b0;
    wait_req(1'b0);
    rchk(HIGH_OFS, 8'hbe);
    rchk(LOW_OFS, 8'hef);
    wait_req(1'b1);
    chk_bit(core_transmit_empty, 1'b1);
    wr(CMD_OFS, 8'h80);
    chk_bit(host_command_irq, 1'b1);
    core_int_ack = 1'b1;
    @(negedge ref_clk);
    core_int_ack = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk_bit(host_command_irq, 1'b0);
    $display("test interrupt mode done");
    wr(ICR_OFS, 8'h00);
    wr(HIGH_OFS, 8'h12);
    wr(LOW_OFS, 8'h34);
    chk_bit(core_receive_full, 1'b1);
    chk_bit(host_receive_exception, 1'b1);
    wr(HIGH_OFS, 8'h56);
    wr(LOW_OFS, 8'h78);
    wr(HIGH_OFS, 8'h9a);
    wr(LOW_OFS, 8'hbc);
    rchk(STAT_OFS, 8'h10);
    pop(16'h1234);
    pop(16'h5678);
    pop(16'h9abc);
    chk_bit(core_receive_full, 1'b0);
    chk_bit(host_receive_exception, 1'b0);
    $display("test host words done");
    // host keeps off the transmit pair while dma runs
    wr(ICR_OFS, 8'hc2);
    rchk(STAT_OFS, 8'hd6);
    wait_req(1'b0);
    i_dma.run('{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66}, 0);
    repeat (10) @(negedge ref_clk);
    chk_bit(host_request_out_n, 1'b1);
    pop(16'h1122);
    wait_req(1'b0);
    pop(16'h3344);
    pop(16'h5566);
    $display("test dma16 done");
    wr(ICR_OFS, 8'he2);
    i_dma.run('{8'h77, 8'h88}, 7);
    repeat (6) @(negedge ref_clk);
    pop(16'h5577);
    pop(16'h5588);
    chk_bit(dma_errs == 0, 1'b1);
    $display("test dma8 done");
    wr(ICR_OFS, 8'h22);
    rchk(STAT_OFS, 8'h56);
    chk_bit(host_request_out_n, 1'b1);
    // other direction is polled only, no request use
    wr(ICR_OFS, 8'h02);
    wait_req(1'b0);
    do_reset();
    chk_bit(host_request_out_n, 1'b1);
    rchk(VEC_OFS, VEC_RST);
    rchk(STAT_OFS, 8'h16);
    core_tx_write = 1'b1;
    @(negedge ref_clk);
    core_tx_write = 1'b0;
    rchk(STAT_OFS, 8'h17);
    wr(ICR_OFS, 8'h81);
    rchk(STAT_OFS, 8'h16);
    chk_bit(core_transmit_empty, 1'b1);
    $display("test reset done");
    final_report();
  end
endmodule : tb_top
